// file: verilog/tcb_map.svh
// Contract
// - Bit test ANDs rs with immediate, two T-states
// - Bit test changes only negative and zero
// - Relative call pushes PC, flags, enable, banks
// - Call target is next address plus displacement
// - Compare subtracts immediate, sets flags, writes nothing
// - Compare carry set when register below immediate
// - Complement inverts any active register, two T-states
// - Exchange selects bank A and B independently
// - Select bit zero main, one alternate
// - Inactive bank registers keep their contents
// - Enable field: keep, set on two, clear three
// - Conditional jump taken when flag equals state
// - Conditional jump pushes nothing, touches no flags
// - Conditions cover zero, carry, overflow, negative
// - Conditions cover four transceiver status flags
// - Data available code differs from status bit
`ifndef TCB_MAP_SVH
`define TCB_MAP_SVH

`define TCB_OPC_MSB 15
`define TCB_OPC_LSB 12
`define TCB_OP_BIT 4'h1
`define TCB_OP_CALL 4'h2
`define TCB_OP_CMP 4'h3
`define TCB_OP_CPL 4'h4
`define TCB_OP_EXX 4'h5
`define TCB_OP_JCC 4'h6

`define TCB_IMM_MSB 11
`define TCB_IMM_LSB 4
`define TCB_LREG_MSB 3
`define TCB_REG_MSB 4
`define TCB_DISP_MSB 7
`define TCB_JF_MSB 11
`define TCB_JF_LSB 9
`define TCB_JS_BIT 8
`define TCB_BA_BIT 5
`define TCB_BB_BIT 4
`define TCB_G_MSB 3
`define TCB_G_LSB 2

`define TCB_TS_SHORT 2'h2
`define TCB_TS_LONG 2'h3

`define TCB_FLG_N 3
`define TCB_FLG_Z 2
`define TCB_FLG_C 1
`define TCB_FLG_V 0

`define TCB_G_KEEP 2'h0
`define TCB_G_SET 2'h2
`define TCB_G_CLR 2'h3

`define TCB_F_Z 3'h0
`define TCB_F_C 3'h1
`define TCB_F_V 3'h2
`define TCB_F_N 3'h3
`define TCB_F_RA 3'h4
`define TCB_F_RE 3'h5
`define TCB_F_DAV 3'h6
`define TCB_F_TFF 3'h7

`define TCB_TSR_RA_BIT 5
`define TCB_TSR_RE_BIT 4
`define TCB_TSR_DAV_BIT 3
`define TCB_TSR_TFF_BIT 6

`define TCB_NUM_PHYS 44
`define TCB_BANK_A_END 5'h04
`define TCB_BANK_B_END 5'h0C
`define TCB_ALT_BASE 6'h20
`define TCB_PC_RESET 16'h0000

`endif

// file: verilog/tcb_pkg.sv
`include "tcb_map.svh"
`default_nettype none
package tcb_pkg;

    typedef enum logic [1:0] {
        TCB_IDLE = 2'h0,
        TCB_EXEC = 2'h1
    } tcb_state_t;

    typedef struct packed {
        tcb_state_t state;
        logic [1:0] cnt;
        logic [15:0] instr;
        logic [15:0] pc;
        logic [3:0] flags;
        logic global_irq_enable;
        logic bank_a;
        logic bank_b;
        logic push_valid;
        logic [22:0] push_data;
        logic done;
        logic [7:0] host_rdata;
        logic [7:0] tsr_s1;
        logic [7:0] tsr_s2;
    } tcb_core_st_t;

    typedef struct packed {
        logic [`TCB_NUM_PHYS-1:0][7:0] regs;
    } tcb_rf_st_t;

endpackage
`default_nettype wire

// file: verilog/tcb_regfile.sv
`include "tcb_map.svh"
`default_nettype none
module tcb_regfile (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic bank_a_sel_in,
    input wire logic bank_b_sel_in,
    input wire logic [4:0] core_addr_in,
    output logic [7:0] core_data_out,
    input wire logic [4:0] host_addr_in,
    output logic [7:0] host_data_out,
    input wire logic wr_en_in,
    input wire logic [4:0] wr_addr_in,
    input wire logic [7:0] wr_data_in
);
    tcb_pkg::tcb_rf_st_t st_r;
    tcb_pkg::tcb_rf_st_t st_nxt;

    // Alternate copies sit above the main 32; unselected copies are never touched
    function automatic logic [5:0] phys(input logic [4:0] a, input logic ba, input logic bb);
        logic alt;
        alt = (a < `TCB_BANK_A_END && ba) ||
              (a >= `TCB_BANK_A_END && a < `TCB_BANK_B_END && bb);
        phys = alt ? `TCB_ALT_BASE + {1'b0, a} : {1'b0, a};
    endfunction

    assign core_data_out = st_r.regs[phys(core_addr_in, bank_a_sel_in, bank_b_sel_in)];
    assign host_data_out = st_r.regs[phys(host_addr_in, bank_a_sel_in, bank_b_sel_in)];

    always_comb begin
        st_nxt = st_r;
        if (wr_en_in) begin
            st_nxt.regs[phys(wr_addr_in, bank_a_sel_in, bank_b_sel_in)] = wr_data_in;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule // tcb_regfile
`default_nettype wire

// file: verilog/tcb_exec.sv
// Design decisions made here: the strobed register port and the register offsets.
`include "tcb_map.svh"
`default_nettype none
module tcb_exec (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic instr_valid_in,
    input wire logic [15:0] instr_in,
    output logic instr_ready_out,
    output logic done_out,
    output logic [15:0] pc_out,
    output logic [3:0] flags_out,
    output logic global_irq_enable_out,
    output logic bank_a_sel_out,
    output logic bank_b_sel_out,
    output logic push_valid_out,
    output logic [22:0] push_data_out,
    input wire logic [7:0] transceiver_status_reg_in,
    input wire logic [4:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out
);
    tcb_pkg::tcb_core_st_t st_r;
    tcb_pkg::tcb_core_st_t st_nxt;

    logic [3:0] op_w;
    logic [7:0] imm_w;
    logic [7:0] disp_w;
    logic [1:0] g_w;
    logic [4:0] core_addr_w;
    logic [7:0] opa_w;
    logic [7:0] host_data_w;
    logic [7:0] and_w;
    logic [8:0] diff_w;
    logic [7:0] cpl_w;
    logic [15:0] target_w;
    logic cond_w;
    logic taken_w;
    logic last_w;
    logic accept_w;
    logic rf_we;
    logic [4:0] rf_waddr;
    logic [7:0] rf_wdata;

    function automatic logic [1:0] tstates(input logic [3:0] op);
        case (op)
            `TCB_OP_CALL: tstates = `TCB_TS_LONG;
            `TCB_OP_JCC: tstates = `TCB_TS_LONG;
            default: tstates = `TCB_TS_SHORT;
        endcase
    endfunction

    // Status code numbering is not the status register's bit numbering
    function automatic logic flag_sel(input logic [2:0] f, input logic [3:0] fl,
                                      input logic [7:0] transceiver_status_reg);
        case (f)
            `TCB_F_Z: flag_sel = fl[`TCB_FLG_Z];
            `TCB_F_C: flag_sel = fl[`TCB_FLG_C];
            `TCB_F_V: flag_sel = fl[`TCB_FLG_V];
            `TCB_F_N: flag_sel = fl[`TCB_FLG_N];
            `TCB_F_RA: flag_sel = transceiver_status_reg[`TCB_TSR_RA_BIT];
            `TCB_F_RE: flag_sel = transceiver_status_reg[`TCB_TSR_RE_BIT];
            `TCB_F_DAV: flag_sel = transceiver_status_reg[`TCB_TSR_DAV_BIT];
            `TCB_F_TFF: flag_sel = transceiver_status_reg[`TCB_TSR_TFF_BIT];
            default: flag_sel = 1'b0;
        endcase
    endfunction

    assign op_w = st_r.instr[`TCB_OPC_MSB:`TCB_OPC_LSB];
    assign imm_w = st_r.instr[`TCB_IMM_MSB:`TCB_IMM_LSB];
    assign disp_w = st_r.instr[`TCB_DISP_MSB:0];
    assign g_w = st_r.instr[`TCB_G_MSB:`TCB_G_LSB];
    // Limited forms reach only the first sixteen active registers
    assign core_addr_w = (op_w == `TCB_OP_CPL) ? st_r.instr[`TCB_REG_MSB:0]
                                               : {1'b0, st_r.instr[`TCB_LREG_MSB:0]};
    assign and_w = opa_w & imm_w;
    assign diff_w = {1'b0, opa_w} - {1'b0, imm_w};
    assign cpl_w = ~opa_w;
    assign target_w = st_r.pc + {{8{disp_w[7]}}, disp_w};
    assign cond_w = flag_sel(st_r.instr[`TCB_JF_MSB:`TCB_JF_LSB], st_r.flags, st_r.tsr_s2);
    assign taken_w = (cond_w == st_r.instr[`TCB_JS_BIT]);
    assign last_w = (st_r.state == tcb_pkg::TCB_EXEC) && (st_r.cnt == 2'h1);
    assign accept_w = instr_valid_in && instr_ready_out;

    assign instr_ready_out = (st_r.state == tcb_pkg::TCB_IDLE);
    assign done_out = st_r.done;
    assign pc_out = st_r.pc;
    assign flags_out = st_r.flags;
    assign global_irq_enable_out = st_r.global_irq_enable;
    assign bank_a_sel_out = st_r.bank_a;
    assign bank_b_sel_out = st_r.bank_b;
    assign push_valid_out = st_r.push_valid;
    assign push_data_out = st_r.push_data;
    assign reg_rdata_out = st_r.host_rdata;

    tcb_regfile u_regfile (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .bank_a_sel_in(st_r.bank_a),
        .bank_b_sel_in(st_r.bank_b),
        .core_addr_in(core_addr_w),
        .core_data_out(opa_w),
        .host_addr_in(reg_addr_in),
        .host_data_out(host_data_w),
        .wr_en_in(rf_we),
        .wr_addr_in(rf_waddr),
        .wr_data_in(rf_wdata)
    );

    always_comb begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        st_nxt.push_valid = 1'b0;
        st_nxt.host_rdata = reg_rd_in ? host_data_w : 8'h00;
        st_nxt.tsr_s1 = transceiver_status_reg_in;
        st_nxt.tsr_s2 = st_r.tsr_s1;
        rf_we = 1'b0;
        rf_waddr = reg_addr_in;
        rf_wdata = reg_wdata_in;
        case (st_r.state)
            tcb_pkg::TCB_IDLE: begin
                if (accept_w) begin
                    st_nxt.instr = instr_in;
                    st_nxt.pc = st_r.pc + 16'h0001;
                    st_nxt.cnt = tstates(instr_in[`TCB_OPC_MSB:`TCB_OPC_LSB]) - 2'h1;
                    st_nxt.state = tcb_pkg::TCB_EXEC;
                end else if (reg_wr_in) begin
                    // Host writes only land while no instruction is in flight
                    rf_we = 1'b1;
                end
            end
            tcb_pkg::TCB_EXEC: begin
                if (st_r.cnt != 2'h1) begin
                    st_nxt.cnt = st_r.cnt - 2'h1;
                end else begin
                    st_nxt.state = tcb_pkg::TCB_IDLE;
                    st_nxt.done = 1'b1;
                    case (op_w)
                        `TCB_OP_BIT: begin
                            st_nxt.flags[`TCB_FLG_N] = and_w[7];
                            st_nxt.flags[`TCB_FLG_Z] = (and_w == 8'h00);
                        end
                        `TCB_OP_CALL: begin
                            st_nxt.push_valid = 1'b1;
                            st_nxt.push_data = {st_r.pc, st_r.global_irq_enable, st_r.flags,
                                                st_r.bank_a, st_r.bank_b};
                            st_nxt.pc = target_w;
                        end
                        `TCB_OP_CMP: begin
                            st_nxt.flags[`TCB_FLG_N] = diff_w[7];
                            st_nxt.flags[`TCB_FLG_Z] = (diff_w[7:0] == 8'h00);
                            st_nxt.flags[`TCB_FLG_C] = diff_w[8];
                            st_nxt.flags[`TCB_FLG_V] = (opa_w[7] != imm_w[7]) &&
                                                       (diff_w[7] != opa_w[7]);
                        end
                        `TCB_OP_CPL: begin
                            rf_we = 1'b1;
                            rf_waddr = core_addr_w;
                            rf_wdata = cpl_w;
                            st_nxt.flags[`TCB_FLG_N] = cpl_w[7];
                            st_nxt.flags[`TCB_FLG_Z] = (cpl_w == 8'h00);
                        end
                        `TCB_OP_EXX: begin
                            st_nxt.bank_a = st_r.instr[`TCB_BA_BIT];
                            st_nxt.bank_b = st_r.instr[`TCB_BB_BIT];
                            // Reserved code leaves the enable alone, as the default does
                            case (g_w)
                                `TCB_G_SET: st_nxt.global_irq_enable = 1'b1;
                                `TCB_G_CLR: st_nxt.global_irq_enable = 1'b0;
                                default: st_nxt.global_irq_enable = st_r.global_irq_enable;
                            endcase
                        end
                        `TCB_OP_JCC: begin
                            if (taken_w) begin
                                st_nxt.pc = target_w;
                            end
                        end
                        default: begin
                            st_nxt.pc = st_r.pc;
                        end
                    endcase
                end
            end
            default: begin
                st_nxt.state = tcb_pkg::TCB_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            st_r <= '0;
            st_r.pc <= `TCB_PC_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);

    // A previous done may still stand at the taking edge when issue is back to back
    bit_two_t_a: assert property (
        (accept_w && instr_in[`TCB_OPC_MSB:`TCB_OPC_LSB] == `TCB_OP_BIT)
        |=> !done_out ##1 done_out)
        else $error("bit test did not finish in two cycles");

    bit_cv_keep_a: assert property (
        (last_w && op_w == `TCB_OP_BIT)
        |=> $stable(flags_out[`TCB_FLG_C]) && $stable(flags_out[`TCB_FLG_V]))
        else $error("bit test changed carry or overflow");

    bit_nz_a: assert property (
        (last_w && op_w == `TCB_OP_BIT)
        |=> flags_out[`TCB_FLG_N] == $past(and_w[7])
            && flags_out[`TCB_FLG_Z] == ($past(and_w) == 8'h00))
        else $error("bit test negative or zero wrong");

    call_push_a: assert property (
        (accept_w && instr_in[`TCB_OPC_MSB:`TCB_OPC_LSB] == `TCB_OP_CALL)
        |=> !push_valid_out [*2] ##1 push_valid_out)
        else $error("call push missing or late");

    call_target_a: assert property (
        push_valid_out |-> pc_out == push_data_out[22:7] + {{8{disp_w[7]}}, disp_w})
        else $error("call target wrong");

    cmp_no_write_a: assert property (
        (rf_we && st_r.state == tcb_pkg::TCB_EXEC) |-> op_w == `TCB_OP_CPL)
        else $error("instruction other than complement wrote a register");

    cmp_carry_a: assert property (
        (last_w && op_w == `TCB_OP_CMP)
        |=> flags_out[`TCB_FLG_C] == ($past(opa_w) < $past(imm_w)))
        else $error("compare carry wrong");

    cpl_value_a: assert property (
        (last_w && op_w == `TCB_OP_CPL) |=> opa_w == ~$past(opa_w))
        else $error("complement result wrong");

    exx_bank_a: assert property (
        (last_w && op_w == `TCB_OP_EXX)
        |=> bank_a_sel_out == st_r.instr[`TCB_BA_BIT]
            && bank_b_sel_out == st_r.instr[`TCB_BB_BIT])
        else $error("bank select wrong");

    exx_gie_a: assert property (
        (last_w && op_w == `TCB_OP_EXX)
        |=> global_irq_enable_out == ((g_w == `TCB_G_SET) ? 1'b1 :
            (g_w == `TCB_G_CLR) ? 1'b0 : $past(global_irq_enable_out)))
        else $error("interrupt enable update wrong");

    jcc_target_a: assert property (
        (last_w && op_w == `TCB_OP_JCC)
        |=> pc_out == ($past(taken_w) ? $past(target_w) : $past(pc_out)))
        else $error("conditional jump destination wrong");

    jcc_quiet_a: assert property (
        (last_w && op_w == `TCB_OP_JCC) |=> !push_valid_out && $stable(flags_out))
        else $error("conditional jump pushed or changed flags");

    cmp_nz_a: assert property (
        (last_w && op_w == `TCB_OP_CMP)
        |=> flags_out[`TCB_FLG_N] == $past(diff_w[7])
            && flags_out[`TCB_FLG_Z] == (($past(opa_w) - $past(imm_w)) == 8'h00))
        else $error("compare negative or zero wrong");

    cmp_over_a: assert property (
        (last_w && op_w == `TCB_OP_CMP)
        |=> flags_out[`TCB_FLG_V] == ($past(opa_w[7]) != $past(imm_w[7])
            && $past(diff_w[7]) != $past(opa_w[7])))
        else $error("compare overflow wrong");

    cpl_nz_a: assert property (
        (last_w && op_w == `TCB_OP_CPL)
        |=> flags_out[`TCB_FLG_N] == !$past(opa_w[7])
            && flags_out[`TCB_FLG_Z] == ($past(opa_w) == 8'hFF))
        else $error("complement negative or zero wrong");

    cpl_latency_a: assert property (
        (accept_w && instr_in[`TCB_OPC_MSB:`TCB_OPC_LSB] == `TCB_OP_CPL)
        |=> !done_out ##1 done_out)
        else $error("complement did not finish in two cycles");

    call_push_data_a: assert property (
        (last_w && op_w == `TCB_OP_CALL)
        |=> push_data_out == {$past(pc_out), $past(global_irq_enable_out),
            $past(flags_out), $past(bank_a_sel_out), $past(bank_b_sel_out)})
        else $error("call pushed wrong state");

    call_flags_a: assert property (
        (last_w && op_w == `TCB_OP_CALL)
        |=> $stable(flags_out) && $stable(global_irq_enable_out))
        else $error("call changed flags or interrupt enable");

    push_only_call_a: assert property (
        push_valid_out |-> op_w == `TCB_OP_CALL)
        else $error("push without a call");

    bank_hold_a: assert property (
        !(last_w && op_w == `TCB_OP_EXX)
        |=> $stable(bank_a_sel_out) && $stable(bank_b_sel_out))
        else $error("bank select changed outside exchange");
endmodule // tcb_exec
`default_nettype wire

// file: testbench/tb.sv
`include "tcb_map.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [3:0] rs;
        logic [7:0] val;
        logic [3:0] op;
        logic [7:0] n;
        logic [3:0] fl;
    } tcb_row_t;
    typedef struct packed {
        logic ba;
        logic bb;
        logic [1:0] g;
        logic global_irq_enable;
        logic [31:0] regs;
    } tcb_step_t;

    logic clk_in, reset_in, iv, ir, done, global_irq_enable, ba, bb, pv, wr, rd, pv_done;
    logic [15:0] ins, pc, p;
    logic [3:0] fl, fb;
    logic [22:0] pd;
    logic [7:0] transceiver_status_reg, wd, rdat, d, dp;
    logic [4:0] ad;
    int miscompares = 0;
    int checks = 0;
    int pushes = 0;
    int k;
    // Flag history matters: the bit tests follow rows that set V and C
    tcb_row_t rows [8] = '{
        '{4'h1, 8'h10, `TCB_OP_CMP, 8'h20, 4'hA},
        '{4'h1, 8'h20, `TCB_OP_CMP, 8'h20, 4'h4},
        '{4'h2, 8'h30, `TCB_OP_CMP, 8'h20, 4'h0},
        '{4'h3, 8'h80, `TCB_OP_CMP, 8'h01, 4'h1},
        '{4'h2, 8'h0F, `TCB_OP_BIT, 8'hF0, 4'h5},
        '{4'h4, 8'h00, `TCB_OP_CMP, 8'hFF, 4'h2},
        '{4'hF, 8'h80, `TCB_OP_BIT, 8'h80, 4'hA},
        '{4'hF, 8'h7F, `TCB_OP_CMP, 8'hFF, 4'hB}};
    // Expected R0, R4, R11, R12 as seen through the active banks
    tcb_step_t steps [4] = '{
        '{1'b1, 1'b1, 2'h2, 1'b1, 32'h0000_0099},
        '{1'b0, 1'b1, 2'h1, 1'b1, 32'h1166_0099},
        '{1'b1, 1'b0, 2'h0, 1'b1, 32'h5522_7799},
        '{1'b0, 1'b0, 2'h3, 1'b0, 32'h1122_7799}};
    logic [4:0] probe [4] = '{5'h00, 5'h04, 5'h0B, 5'h0C};
    logic [7:0] cv [2] = '{8'b0101_1010, 8'b1010_1010};
    logic [7:0] tsv [2] = '{8'h28, 8'h50};

    tcb_exec dut_u (.clk_in(clk_in), .reset_in(reset_in), .instr_valid_in(iv), .instr_in(ins),
        .instr_ready_out(ir), .done_out(done), .pc_out(pc), .flags_out(fl),
        .global_irq_enable_out(global_irq_enable), .bank_a_sel_out(ba), .bank_b_sel_out(bb),
        .push_valid_out(pv), .push_data_out(pd), .transceiver_status_reg_in(transceiver_status_reg),
        .reg_addr_in(ad), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdat));

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    always @(posedge clk_in) begin
        if (pv === 1'b1) begin
            pushes <= pushes + 1;
        end
    end

    task automatic chk(input string nm, input logic [22:0] e, input logic [22:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic wreg(input logic [4:0] a, input logic [7:0] v);
        @(posedge clk_in);
        wr <= 1'b1;
        ad <= a;
        wd <= v;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask

    task automatic rreg(input logic [4:0] a);
        @(posedge clk_in);
        rd <= 1'b1;
        ad <= a;
        @(posedge clk_in);
        rd <= 1'b0;
        #1;
        d = rdat;
    endtask

    // Optional host write lands while busy and must be dropped
    task automatic exec(input logic [15:0] w, input int lat, input logic drop);
        int n;
        // Latency counts from the cycle that offers the word
        n = 1;
        @(posedge clk_in);
        iv <= 1'b1;
        ins <= w;
        @(posedge clk_in);
        iv <= 1'b0;
        wr <= drop;
        ad <= 5'h01;
        wd <= 8'hEE;
        do begin
            @(posedge clk_in);
            wr <= 1'b0;
            #1;
            n++;
        end while (done !== 1'b1 && n < 20);
        if (n >= 20) begin
            miscompares++;
            stop_test();
        end
        chk("latency", 23'(lat), 23'(n));
        pv_done = pv;
    endtask

    initial begin
        reset_in = 1'b1;
        iv = 1'b0;
        ins = 16'h0000;
        transceiver_status_reg = 8'h00;
        wd = 8'h00;
        ad = 5'h00;
        wr = 1'b0;
        rd = 1'b0;
        repeat (12) @(posedge clk_in);
        reset_in <= 1'b0;
        #1;
        chk("reset state", 23'h000000, {pc, fl, global_irq_enable, ba, bb});
        chk("ready", 23'h000001, 23'(ir));
        foreach (rows[i]) begin
            p = pc;
            wreg({1'b0, rows[i].rs}, rows[i].val);
            exec({rows[i].op, rows[i].n, rows[i].rs}, 2, 1'b0);
            chk("flags", 23'(rows[i].fl), 23'(fl));
            chk("pc", 23'(p + 16'h0001), 23'(pc));
            rreg({1'b0, rows[i].rs});
            chk("source kept", 23'(rows[i].val), 23'(d));
        end
        wreg(5'h14, 8'h5A);
        wreg(5'h01, 8'h33);
        exec({`TCB_OP_CPL, 7'h00, 5'h14}, 2, 1'b1);
        chk("cpl nz", 23'h000002, 23'(fl[3:2]));
        rreg(5'h14);
        chk("cpl value", 23'h0000A5, 23'(d));
        rreg(5'h01);
        chk("busy write", 23'h000033, 23'(d));
        wreg(5'h14, 8'hFF);
        exec({`TCB_OP_CPL, 7'h00, 5'h14}, 2, 1'b0);
        chk("cpl z", 23'h000001, 23'(fl[3:2]));
        wreg(5'h00, 8'h11);
        wreg(5'h04, 8'h22);
        wreg(5'h0B, 8'h77);
        wreg(5'h0C, 8'h99);
        foreach (steps[i]) begin
            exec({`TCB_OP_EXX, 6'h00, steps[i].ba, steps[i].bb, steps[i].g, 2'h0}, 2, 1'b0);
            chk("banks", 23'({steps[i].ba, steps[i].bb}), 23'({ba, bb}));
            chk("irq enable", 23'(steps[i].global_irq_enable), 23'(global_irq_enable));
            foreach (probe[j]) begin
                rreg(probe[j]);
                chk("banked reg", 23'(steps[i].regs[31 - 8 * j -: 8]), 23'(d));
            end
            if (i == 0) begin
                wreg(5'h00, 8'h55);
                wreg(5'h04, 8'h66);
            end
        end
        for (int c = 0; c < 2; c++) begin
            dp = (c == 0) ? 8'hFE : 8'h7F;
            p = pc;
            fb = fl;
            k = pushes;
            exec({`TCB_OP_CALL, 4'h0, dp}, 3, 1'b0);
            chk("push pulse", 23'h000001, 23'(pv_done));
            chk("push data", {p + 16'h0001, 1'b0, fb, 2'b00}, pd);
            chk("call pc", 23'(16'(p + 16'h0001 + {{8{dp[7]}}, dp})), 23'(pc));
            // The counter takes the pulse at the edge that ends it
            @(posedge clk_in);
            #1;
            chk("push count", 23'(k + 1), 23'(pushes));
        end
        wreg(5'h01, 8'h10);
        exec({`TCB_OP_CMP, 8'h20, 4'h1}, 2, 1'b0);
        k = pushes;
        for (int t = 0; t < 2; t++) begin
            @(posedge clk_in);
            transceiver_status_reg <= tsv[t];
            repeat (3) @(posedge clk_in);
            for (int f = 0; f < 8; f++) begin
                for (int s = 0; s < 2; s++) begin
                    dp = (s == 1) ? 8'h80 : 8'h7F;
                    p = pc + 16'h0001;
                    if (cv[t][f] == 1'(s)) begin
                        p = p + {{8{dp[7]}}, dp};
                    end
                    exec({`TCB_OP_JCC, 3'(f), 1'(s), dp}, 3, 1'b0);
                    chk("jump pc", 23'(p), 23'(pc));
                    chk("jump flags", 23'h00000A, 23'(fl));
                end
            end
        end
        chk("jump pushes", 23'(k), 23'(pushes));
        @(posedge clk_in);
        reset_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        reset_in <= 1'b0;
        #1;
        chk("second reset", 23'h000000, {pc, fl, global_irq_enable, ba, bb});
        rreg(5'h00);
        chk("reg after reset", 23'h000000, 23'(d));
        stop_test();
    end
endmodule // tb
`default_nettype wire
